/* File: sac_pkg.sv */
// Shared constants and types for the successive-approximation converter control block.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package sac_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_CSA = 8'h04;
  localparam logic [7:0] OFF_CSB = 8'h08;
  localparam logic [7:0] OFF_RLO = 8'h0C;
  localparam logic [7:0] OFF_RHI = 8'h10;
  localparam logic [7:0] OFF_PWR = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SEL_CH_LSB = 0;
  localparam int SEL_LADJ_BIT = 5;
  localparam int SEL_REF_LSB = 6;
  localparam int CSA_PS_LSB = 0;
  localparam int CSA_FLAG_BIT = 4;
  localparam int CSA_ATE_BIT = 5;
  localparam int CSA_START_BIT = 6;
  localparam int CSA_EN_BIT = 7;
  localparam int CSB_TS_LSB = 0;
  localparam int PWR_BIT = 0;
  localparam logic [7:0] SEL_WMASK = 8'hEF;

  // ==========================================================================
  // Reset values and encodings
  // ==========================================================================
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] CSA_RST = 8'h00;
  localparam logic [7:0] CSB_RST = 8'h00;
  localparam logic PWR_RST = 1'b0;
  localparam logic [3:0] CH_BANDGAP = 4'hE;
  localparam logic [3:0] CH_GND = 4'hF;
  localparam logic [1:0] REF_PIN = 2'h0;
  localparam logic [1:0] REF_RSVD = 2'h2;
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  localparam logic [2:0] PS_MIN_SHIFT = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Conversion timing, counted in half converter clock cycles
  // ==========================================================================
  // Normal: hold at 1.5 cycles, done at 13 cycles.
  localparam logic [5:0] NORM_SH = 6'h03;
  localparam logic [5:0] NORM_END = 6'h1A;
  // First after enable: hold at 13.5 cycles, done at 25 cycles.
  localparam logic [5:0] FIRST_SH = 6'h1B;
  localparam logic [5:0] FIRST_END = 6'h32;
  // Auto-triggered: hold at 2 cycles, done at 13.5 cycles.
  localparam logic [5:0] AUTO_SH = 6'h04;
  localparam logic [5:0] AUTO_END = 6'h1B;
  // The final converter cycle spans two half cycles.
  localparam logic [5:0] LAST_CYCLE_HC = 6'h02;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT = 2'b01,
    SAC_CONV = 2'b11
  } sac_conv_e;

endpackage : sac_pkg

/* File: sac_presc_if.sv */
// Link between the sequencer and the converter clock prescaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface sac_presc_if;
  logic en;
  logic clr;
  logic [2:0] div_sel;
  logic rise;
  logic fall;
  modport ctrl (output en, output clr, output div_sel, input rise, input fall);
  modport presc (input en, input clr, input div_sel, output rise, output fall);
endinterface : sac_presc_if

/* File: sac_presc.sv */
// Converter clock prescaler: one-cycle pulses on the rising and falling edges of the divided clock.
// Assumes the controller holds en low whenever the converter is disabled.
`timescale 1ns/1ps
module sac_presc #(
  parameter int DIV_W = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  sac_presc_if.presc pif
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  // The largest divisor is 128, so the counter needs seven bits.
  if (DIV_W < 7) begin : g_bad_width
    $error("sac_presc: DIV_W must be at least 7");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic rise;
    logic fall;
  } sac_presc_s;

  sac_presc_s q;
  sac_presc_s n;
  logic [2:0] shift;
  logic [DIV_W-1:0] lim;

  // ==========================================================================
  // Divider
  // ==========================================================================
  always_comb begin
    n = q;
    shift = (pif.div_sel < sac_pkg::PS_MIN_SHIFT) ? sac_pkg::PS_MIN_SHIFT : pif.div_sel;
    lim = DIV_W'((32'h0000_0001 << shift) - 32'h0000_0001);
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (!pif.en || pif.clr) begin
      n.cnt = '0;
    end else begin
      n.rise = (q.cnt == lim);
      n.fall = (q.cnt == (lim >> 1));
      n.cnt = (q.cnt == lim) ? '0 : q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign pif.rise = q.rise;
  assign pif.fall = q.fall;

  presc_hold_a: assert property (@(posedge clk) disable iff (sys_rst) (ce && !pif.en) |=> (q.cnt == '0 && !q.rise))
    else $error("prescaler counts while disabled");

endmodule : sac_presc

/* File: sac_top.sv */
// Conversion control for a 10-bit successive-approximation converter with an AXI4-Lite register file.
// Assumes trigger sources and the SAR result are synchronous to clk; the analog core samples on sample_hold.
// Behaviour
// - Converter idle and selections frozen until enabled
// - Prescaler runs while enabled, reset otherwise
// - Start bit begins conversion, clears at end; stays set while free-running
// - Conversion begins on next converter clock rise
// - Thirteen cycles normally, twenty-five first time
// - Hold at 1.5 or 13.5 cycles
// - Triggered: hold at two, done 13.5
// - Completion stores result, sets flag, clears start; free-running keeps start set
// - Trigger edge resets prescaler, starts conversion
// - Trigger edges during conversion are ignored
// - Trigger flags need clearing for new edge
// - Flag source restarts conversion immediately, free-running
// - Start bit works with auto trigger; shows busy
// - Channel change waits for current conversion
// - Result right-aligned, or left-aligned on select
// - Low byte read locks result until high
// - Flag still set when result discarded
// - Channel field picks pin, ground or bandgap
// - Reference field picks supply, 1.1V or pin
// - Selections buffered, locked during conversion
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sac_top #(
  parameter int DIV_W = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [6:0] trig_src,
  input wire logic [9:0] sar_result,
  output logic analog_enable,
  output logic [3:0] input_channel_select,
  output logic [1:0] reference_select_bits,
  output logic sample_hold,
  output logic conv_active,
  output logic conversion_complete_flag
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] sel;
    logic [7:0] csa;
    logic [7:0] csb;
    logic pwr;
    logic [9:0] res;
    logic lock;
    sac_pkg::sac_conv_e st;
    logic [5:0] half;
    logic first;
    logic auto_run;
    logic [2:0] trig_sh;
    logic trig_edge;
    logic [3:0] ch_app;
    logic [1:0] ref_app;
    logic sh;
    logic active;
    logic presc_clr;
    logic analog_en;
  } sac_state_s;

  localparam sac_state_s RST_STATE = '{
    sel: sac_pkg::SEL_RST,
    csa: sac_pkg::CSA_RST,
    csb: sac_pkg::CSB_RST,
    pwr: sac_pkg::PWR_RST,
    st: sac_pkg::SAC_IDLE,
    first: 1'b1,
    default: '0
  };

  sac_state_s q;
  sac_state_s n;
  logic en_eff;
  logic done;
  logic follow;
  logic free_run;
  logic trig_pick;
  logic [2:0] ts;
  logic [5:0] sh_pt;
  logic [5:0] end_pt;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [3:0] ch_req;
  logic [1:0] ref_req;

  sac_presc_if pif ();

  sac_presc #(
    .DIV_W(DIV_W)
  ) u_presc (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pif(pif)
  );

  assign pif.en = q.analog_en;
  assign pif.clr = q.presc_clr;
  assign pif.div_sel = q.csa[sac_pkg::CSA_PS_LSB +: 3];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    n = q;
    done = 1'b0;
    ts = q.csb[sac_pkg::CSB_TS_LSB +: 3];
    free_run = q.csa[sac_pkg::CSA_ATE_BIT] && (ts == sac_pkg::TS_FREE_RUN);
    sh_pt = q.first ? sac_pkg::FIRST_SH : (q.auto_run ? sac_pkg::AUTO_SH : sac_pkg::NORM_SH);
    end_pt = q.first ? sac_pkg::FIRST_END : (q.auto_run ? sac_pkg::AUTO_END : sac_pkg::NORM_END);
    if (q.sel[sac_pkg::SEL_LADJ_BIT]) begin
      res_lo = {q.res[1:0], 6'h00};
      res_hi = q.res[9:2];
    end else begin
      res_lo = q.res[7:0];
      res_hi = {6'h00, q.res[9:8]};
    end

    // Write channel: address and data are captured independently, then applied together.
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = sac_pkg::RESP_OKAY;
      case (q.awaddr[7:2])
        sac_pkg::OFF_SEL[7:2]: begin
          if (q.wstrb[0]) begin
            n.sel = q.wdata[7:0] & sac_pkg::SEL_WMASK;
          end
        end
        sac_pkg::OFF_CSA[7:2]: begin
          if (q.wstrb[0]) begin
            n.csa[sac_pkg::CSA_EN_BIT] = q.wdata[sac_pkg::CSA_EN_BIT];
            n.csa[sac_pkg::CSA_ATE_BIT] = q.wdata[sac_pkg::CSA_ATE_BIT];
            n.csa[sac_pkg::CSA_PS_LSB +: 3] = q.wdata[sac_pkg::CSA_PS_LSB +: 3];
            if (q.wdata[sac_pkg::CSA_START_BIT]) begin
              n.csa[sac_pkg::CSA_START_BIT] = 1'b1;
            end
            if (q.wdata[sac_pkg::CSA_FLAG_BIT]) begin
              n.csa[sac_pkg::CSA_FLAG_BIT] = 1'b0;
            end
          end
        end
        sac_pkg::OFF_CSB[7:2]: begin
          if (q.wstrb[0]) begin
            n.csb = {5'h00, q.wdata[sac_pkg::CSB_TS_LSB +: 3]};
          end
        end
        sac_pkg::OFF_RLO[7:2], sac_pkg::OFF_RHI[7:2]: begin
          n.bresp = sac_pkg::RESP_OKAY;
        end
        sac_pkg::OFF_PWR[7:2]: begin
          if (q.wstrb[0]) begin
            n.pwr = q.wdata[sac_pkg::PWR_BIT];
          end
        end
        default: begin
          n.bresp = sac_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    // Read channel.
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = sac_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (s_axi_araddr[7:2])
        sac_pkg::OFF_SEL[7:2]: n.rdata[7:0] = q.sel;
        sac_pkg::OFF_CSA[7:2]: n.rdata[7:0] = q.csa;
        sac_pkg::OFF_CSB[7:2]: n.rdata[7:0] = q.csb;
        sac_pkg::OFF_RLO[7:2]: begin
          n.rdata[7:0] = res_lo;
          n.lock = 1'b1;
        end
        sac_pkg::OFF_RHI[7:2]: begin
          n.rdata[7:0] = res_hi;
          n.lock = 1'b0;
        end
        sac_pkg::OFF_PWR[7:2]: n.rdata[sac_pkg::PWR_BIT] = q.pwr;
        default: n.rresp = sac_pkg::RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;

    en_eff = n.csa[sac_pkg::CSA_EN_BIT] && !n.pwr;

    trig_pick = (ts == sac_pkg::TS_FREE_RUN) ? 1'b0 : trig_src[ts - 3'h1];
    n.trig_sh = {q.trig_sh[1:0], trig_pick};
    n.trig_edge = q.trig_sh[1] && !q.trig_sh[2];

    // Sequencer.
    n.sh = 1'b0;
    n.presc_clr = 1'b0;
    if (!en_eff) begin
      n.st = sac_pkg::SAC_IDLE;
      n.half = 6'h00;
      n.first = 1'b1;
      n.auto_run = 1'b0;
      n.csa[sac_pkg::CSA_START_BIT] = 1'b0;
    end else begin
      unique case (q.st)
        sac_pkg::SAC_IDLE: begin
          if (q.csa[sac_pkg::CSA_ATE_BIT] && q.trig_edge && ts != sac_pkg::TS_FREE_RUN) begin
            n.st = sac_pkg::SAC_CONV;
            n.half = 6'h00;
            n.auto_run = 1'b1;
            n.presc_clr = 1'b1;
            n.csa[sac_pkg::CSA_START_BIT] = 1'b1;
          end else if (q.csa[sac_pkg::CSA_START_BIT]) begin
            n.st = sac_pkg::SAC_WAIT;
          end
        end
        sac_pkg::SAC_WAIT: begin
          if (pif.rise) begin
            n.st = sac_pkg::SAC_CONV;
            n.half = 6'h00;
            n.auto_run = 1'b0;
          end
        end
        sac_pkg::SAC_CONV: begin
          if ((pif.rise || pif.fall) && !q.presc_clr) begin
            n.half = q.half + 6'h01;
            n.sh = (n.half == sh_pt);
            done = (n.half == end_pt);
          end
        end
      endcase
    end

    if (done) begin
      n.first = 1'b0;
      n.csa[sac_pkg::CSA_FLAG_BIT] = 1'b1;
      if (!n.lock) begin
        n.res = sar_result;
      end
      if (free_run) begin
        n.half = 6'h00;
        n.auto_run = 1'b0;
      end else begin
        n.st = sac_pkg::SAC_IDLE;
        n.csa[sac_pkg::CSA_START_BIT] = 1'b0;
      end
    end

    ch_req = q.sel[sac_pkg::SEL_CH_LSB +: 4];
    if (ch_req > 4'h7 && ch_req != sac_pkg::CH_BANDGAP) begin
      ch_req = sac_pkg::CH_GND;
    end
    ref_req = q.sel[sac_pkg::SEL_REF_LSB +: 2];
    if (ref_req == sac_pkg::REF_RSVD) begin
      ref_req = sac_pkg::REF_PIN;
    end
    follow = (q.st != sac_pkg::SAC_CONV) || (q.half >= end_pt - sac_pkg::LAST_CYCLE_HC);
    if (en_eff && follow) begin
      n.ch_app = ch_req;
      n.ref_app = ref_req;
    end
    n.active = (n.st == sac_pkg::SAC_CONV);
    n.analog_en = en_eff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= RST_STATE;
    end else if (ce) begin
      q <= n;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign analog_enable = q.analog_en;
  assign input_channel_select = q.ch_app;
  assign reference_select_bits = q.ref_app;
  assign sample_hold = q.sh;
  assign conv_active = q.active;
  assign conversion_complete_flag = q.csa[sac_pkg::CSA_FLAG_BIT];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  flag_set_a: assert property ((ce && done) |=> q.csa[sac_pkg::CSA_FLAG_BIT])
    else $error("flag not set after completion");
  start_clear_a: assert property ((ce && done && !free_run) |=> (!q.csa[sac_pkg::CSA_START_BIT] && !q.active))
    else $error("start bit not cleared after single conversion");
  free_keep_a: assert property ((ce && done && free_run && en_eff) |=> (q.csa[sac_pkg::CSA_START_BIT] && q.active && q.half == 6'h00))
    else $error("free-running conversion did not restart");
  lock_keep_a: assert property ((ce && done && n.lock) |=> $stable(q.res))
    else $error("locked result was overwritten");
  busy_reads_a: assert property ((q.st == sac_pkg::SAC_CONV) |-> q.csa[sac_pkg::CSA_START_BIT])
    else $error("start bit low during conversion");
  sel_lock_a: assert property ((ce && q.st == sac_pkg::SAC_CONV && !follow) |=> ($stable(q.ch_app) && $stable(q.ref_app)))
    else $error("selection changed mid conversion");
  off_idle_a: assert property ((ce && !en_eff) |=> (q.st == sac_pkg::SAC_IDLE && !q.active && !q.analog_en))
    else $error("converter active while disabled");
  trig_start_a: assert property ((ce && q.st == sac_pkg::SAC_IDLE && en_eff && q.csa[sac_pkg::CSA_ATE_BIT] && q.trig_edge && ts != sac_pkg::TS_FREE_RUN) |=> (q.active && q.presc_clr && q.auto_run))
    else $error("trigger edge did not start conversion");
  trig_ignore_a: assert property ((ce && q.st == sac_pkg::SAC_CONV && !done && en_eff) |=> (q.st == sac_pkg::SAC_CONV && !q.presc_clr))
    else $error("conversion disturbed before completion");

endmodule : sac_top

/* File: sac_far_model.sv */
// Model of the far side: trigger sources and the analog core result.
// Assumes the bench asks for one trigger event at a time with a one-cycle fire request.
`timescale 1ns/1ps
module sac_far_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] fire_sel,
  input wire logic [9:0] value,
  output logic [6:0] trig_src,
  output logic [9:0] sar_result
);
  logic [5:0] hold_r;
  logic [2:0] line_r;
  initial begin
    hold_r = 6'h00;
    line_r = 3'h0;
  end
  // ==========================================================================
  // Trigger level
  // ==========================================================================
  // The level is held long enough to outlast a conversion, so a stuck-high source is seen.
  // source flag dropped before next event
  always @(posedge clk) begin
    if (fire) begin
      hold_r <= 6'h28;
      line_r <= fire_sel;
    end else if (hold_r != 6'h00) begin
      hold_r <= hold_r - 6'h01;
    end
  end
  assign trig_src = (hold_r != 6'h00 && line_r != 3'h0) ? (7'h01 << (line_r - 3'h1)) : 7'h00;
  assign sar_result = value;
endmodule : sac_far_model

/* File: tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the far-side model in sac_far_model and the design files compiled before it.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] C_EN = 32'h0000_0001 << sac_pkg::CSA_EN_BIT;
  localparam logic [31:0] C_GO = 32'h0000_0001 << sac_pkg::CSA_START_BIT;
  localparam logic [31:0] C_AT = 32'h0000_0001 << sac_pkg::CSA_ATE_BIT;
  localparam logic [31:0] C_FL = 32'h0000_0001 << sac_pkg::CSA_FLAG_BIT;
  localparam logic [31:0] C_PS = 32'h0000_0001;
  logic clk, sys_rst, ce, fire, flag, aen, sh, act;
  logic awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [3:0] ws, ch_out, ch, ch2;
  logic [1:0] bresp, rresp, rsp, ref_out;
  logic [6:0] trig_src;
  logic [9:0] sar_result, res_val, old_val;
  logic [2:0] fire_sel;
  int miscompares, n_tests, cyc, sh_cyc, t0, d1, d2;
  sac_top #(.DIV_W(7)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .trig_src(trig_src), .sar_result(sar_result),
    .analog_enable(aen), .input_channel_select(ch_out), .reference_select_bits(ref_out),
    .sample_hold(sh), .conv_active(act), .conversion_complete_flag(flag));
  sac_far_model far (.clk(clk), .fire(fire), .fire_sel(fire_sel), .value(res_val),
    .trig_src(trig_src), .sar_result(sar_result));
  // ==========================================================================
  // Clock, cycle count, watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sh) sh_cyc <= cyc;
  end
  // The whole run needs under a thousand cycles; twenty thousand leaves ample margin.
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  function automatic logic [31:0] lo_exp(input logic [9:0] v, input logic l);
    return l ? {24'h0000_00, v[1:0], 6'h00} : {24'h0000_00, v[7:0]};
  endfunction : lo_exp
  function automatic logic [31:0] hi_exp(input logic [9:0] v, input logic l);
    return l ? {24'h0000_00, v[9:2]} : {30'h0000_0000, v[9:8]};
  endfunction : hi_exp
  // Address and data are offered together; each is released at its own handshake.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awr) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr_r) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    r = bresp;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    r = rresp;
  endtask : bus_rd
  // Waits for completion and checks the hold-to-done spacing at divide-by-two.
  task automatic wait_flag();
    do @(posedge clk); while (flag !== 1'b1);
    check("hold_to_done", 32'((cyc - sh_cyc) inside {[22:24]}), 32'h0000_0001);
  endtask : wait_flag
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {awv, wv, br, arv, rr, fire, fire_sel, awa, ara, wd, sh_cyc, cyc} = '0;
    ws = 4'hF;
    ce = 1'b1;
    sys_rst = 1'b1;
    res_val = 10'h000;
    void'($urandom(3));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      bus_rd(8'(i * 4), rd, rsp);
      check("reset_value", rd, 32'h0000_0000);
    end
    bus_rd(8'h18, rd, rsp);
    check("unmapped_read", 32'(rsp), 32'(sac_pkg::RESP_SLVERR));
    bus_wr(8'h18, 32'h0000_00FF, rsp);
    check("unmapped_write", 32'(rsp), 32'(sac_pkg::RESP_SLVERR));
    bus_wr(sac_pkg::OFF_PWR, 32'h0000_0001, rsp);
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_PS, rsp);
    check("power_reduced", 32'(aen), 32'h0000_0000);
    bus_wr(sac_pkg::OFF_PWR, 32'h0000_0000, rsp);
    check("enabled", 32'(aen), 32'h0000_0001);
    bus_wr(sac_pkg::OFF_CSA, 32'h0000_0000, rsp);
    ch = 4'($urandom % 8);
    ch2 = (ch + 4'h1) & 4'h7;
    res_val = 10'($urandom);
    bus_wr(sac_pkg::OFF_SEL, {24'h0000_00, 2'b01, 2'b00, ch}, rsp);
    check("sel_disabled", 32'(ch_out), 32'h0000_0000);
    t0 = cyc;
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_GO | C_PS, rsp);
    wait_flag();
    d1 = cyc - t0;
    bus_rd(sac_pkg::OFF_CSA, rd, rsp);
    check("start_cleared", rd, C_EN | C_FL | C_PS);
    check("channel", 32'(ch_out), 32'(ch));
    check("reference", 32'(ref_out), 32'h0000_0001);
    bus_rd(sac_pkg::OFF_RLO, rd, rsp);
    check("low_right", rd, lo_exp(res_val, 1'b0));
    bus_rd(sac_pkg::OFF_RHI, rd, rsp);
    check("high_right", rd, hi_exp(res_val, 1'b0));
    res_val = 10'($urandom);
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_FL | C_PS, rsp);
    t0 = cyc;
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_GO | C_PS, rsp);
    bus_wr(sac_pkg::OFF_SEL, {24'h0000_00, 2'b11, 2'b10, ch2}, rsp);
    check("channel_held", 32'(ch_out), 32'(ch));
    wait_flag();
    d2 = cyc - t0;
    check("first_longer", 32'((d1 - d2) inside {[23:25]}), 32'h0000_0001);
    check("channel_new", 32'(ch_out), 32'(ch2));
    check("reference_new", 32'(ref_out), 32'h0000_0003);
    bus_rd(sac_pkg::OFF_RLO, rd, rsp);
    check("low_left", rd, lo_exp(res_val, 1'b1));
    old_val = res_val;
    res_val = 10'($urandom);
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_FL | C_GO | C_PS, rsp);
    wait_flag();
    bus_rd(sac_pkg::OFF_CSA, rd, rsp);
    check("flag_when_locked", rd, C_EN | C_FL | C_PS);
    bus_rd(sac_pkg::OFF_RHI, rd, rsp);
    check("high_locked", rd, hi_exp(old_val, 1'b1));
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_FL | C_GO | C_PS, rsp);
    wait_flag();
    bus_rd(sac_pkg::OFF_RLO, rd, rsp);
    check("low_unlocked", rd, lo_exp(res_val, 1'b1));
    bus_rd(sac_pkg::OFF_RHI, rd, rsp);
    for (int s = 1; s < 8; s++) begin
      res_val = 10'($urandom);
      bus_wr(sac_pkg::OFF_CSB, 32'(s), rsp);
      bus_wr(sac_pkg::OFF_CSA, C_EN | C_AT | C_FL | C_PS, rsp);
      fire_sel <= 3'(s);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (6) @(posedge clk);
      bus_rd(sac_pkg::OFF_CSA, rd, rsp);
      check("auto_busy", 32'(rd[sac_pkg::CSA_START_BIT]), 32'h0000_0001);
      wait_flag();
      bus_rd(sac_pkg::OFF_RLO, rd, rsp);
      check("triggered_result", rd, lo_exp(res_val, 1'b1));
      bus_rd(sac_pkg::OFF_RHI, rd, rsp);
      repeat (12) @(posedge clk);
      check("no_level_restart", 32'(act), 32'h0000_0000);
    end
    ch = 4'h8 | 4'($urandom % 8);
    bus_wr(sac_pkg::OFF_SEL, {24'h0000_00, 2'b10, 2'b00, ch}, rsp);
    @(posedge clk);
    check("channel_map", 32'(ch_out), (ch == sac_pkg::CH_BANDGAP) ? 32'(sac_pkg::CH_BANDGAP) : 32'(sac_pkg::CH_GND));
    check("reference_map", 32'(ref_out), 32'(sac_pkg::REF_PIN));
    bus_wr(sac_pkg::OFF_CSB, 32'(sac_pkg::TS_FREE_RUN), rsp);
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_AT | C_GO | C_FL | C_PS, rsp);
    wait_flag();
    bus_wr(sac_pkg::OFF_CSA, C_EN | C_AT | C_FL | C_PS, rsp);
    wait_flag();
    bus_rd(sac_pkg::OFF_CSA, rd, rsp);
    check("free_run_busy", 32'(rd[sac_pkg::CSA_START_BIT]), 32'h0000_0001);
    bus_wr(sac_pkg::OFF_CSA, 32'h0000_0000, rsp);
    repeat (2) @(posedge clk);
    check("disabled", 32'({aen, act}), 32'h0000_0000);
    summarize();
  end
endmodule : tb_top
